// ===== design/fai_regs.svh
`ifndef FAI_REGS_SVH
`define FAI_REGS_SVH

// Word offsets of the command sequence
`define FAI_UNLOCK1_ADDR  11'h555
`define FAI_UNLOCK2_ADDR  11'h2aa
`define FAI_CMD_ADDR      11'h555
`define FAI_EXIT_ADDR     11'h000
// Command data values
`define FAI_UNLOCK1_DATA  16'h00aa
`define FAI_UNLOCK2_DATA  16'h0055
`define FAI_ID_CMD_DATA   16'h0090
`define FAI_EXIT_DATA     16'h00f0
// Item select codes on A3..A0 (A6 low)
`define FAI_ITEM_MANUF    4'h0
`define FAI_ITEM_DEV1     4'h1
`define FAI_ITEM_PROT     4'h2
`define FAI_ITEM_SECURE   4'h3
`define FAI_ITEM_DEV2     4'he
`define FAI_ITEM_DEV3     4'hf
// Bus phase timing in core_clk cycles
`define FAI_SETUP_CYC     4'h2
`define FAI_STROBE_CYC    4'h9
`define FAI_HOLD_CYC      4'h2
// Sector protection answer bit
`define FAI_PROT_BIT      0

`endif

// ===== design/fai_pkg.sv
package fai_pkg;

	typedef enum logic [2:0] {
		FAI_OP_ENTER   = 3'h0,
		FAI_OP_READ    = 3'h1,
		FAI_OP_EXIT    = 3'h2,
		FAI_OP_HV_ON   = 3'h3,
		FAI_OP_HV_OFF  = 3'h4
	} fai_op_t;

	typedef struct packed {
		fai_op_t     op;
		logic [3:0]  item;
		logic [9:0]  sector;
	} fai_req_t;

	typedef struct packed {
		logic        ce_n;
		logic        oe_n;
		logic        we_n;
		logic        a9_hv;
	} fai_ctl_t;

endpackage

// ===== design/fai_host.sv
`timescale 1ns/100ps
`include "fai_regs.svh"

// What this block does
// - Identification mode is entered either by the command sequence or by high voltage on A9.
// - In high-voltage entry the host holds A9 at the identification level throughout the reads.
// - The host never sends the entry sequence while the device is busy programming or erasing.
// - The host leaves the mode by writing the reset command.
// - For a protection query the sector goes on the top address bits, other bits don't care.
// - A6 low and A3..A0 select the item read (manufacturer, device words, protection, secure).
// - An identification read is a plain read with chip select and output enable low, write enable high.
// - High voltage on A9 is applied only after power-up and removed when power good is low while the host is idle.
// - Entry is three word writes: unlock one at 0x555, unlock two at 0x2aa, command at 0x555.
module fai_host #(
	parameter int ADDR_W = 26,
	parameter int SECT_W = 10
) (
	input  wire logic                 core_clk,
	input  wire logic                 rst,
	input  wire fai_pkg::fai_req_t    req,
	input  wire logic                 req_valid,
	input  wire logic                 dev_busy,
	input  wire logic                 power_good,
	input  wire logic [15:0]          dq_in,
	output logic                      req_ready,
	output logic                      rsp_valid,
	output logic [15:0]               rsp_data,
	output logic                      rsp_protected,
	output logic                      in_id_mode,
	output logic                      req_error,
	output logic [ADDR_W-1:0]         addr,
	output logic [15:0]               dq_out,
	output logic                      dq_oe,
	output fai_pkg::fai_ctl_t         ctl
);

	// Refuse widths the address map cannot serve
	if (ADDR_W < 16 || SECT_W < 1 || SECT_W > 10 || SECT_W > ADDR_W - 16) begin : g_bad_width
		$error("fai_host: unsupported address or sector width");
	end

	typedef enum logic [4:0] {
		ST_IDLE   = 5'b00001,
		ST_SETUP  = 5'b00010,
		ST_STROBE = 5'b00100,
		ST_HOLD   = 5'b01000,
		ST_DONE   = 5'b10000
	} fai_st_t;

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Item read address: sector on top bits, A6 low, item on A3..A0
	function automatic logic [ADDR_W-1:0] item_addr(input logic [9:0] sect, input logic [3:0] it);
		logic [ADDR_W-1:0] a;
		a = '0;
		a[ADDR_W-1 -: SECT_W] = sect[SECT_W-1:0];
		a[3:0] = it;
		return a;
	endfunction

	function automatic logic [ADDR_W-1:0] word_addr(input logic [10:0] off);
		return {{(ADDR_W-11){1'b0}}, off};
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// State

	fai_st_t            st_ff, nxt_st;
	logic [3:0]         cnt_ff, nxt_cnt;
	logic [1:0]         step_ff, nxt_step;
	logic [1:0]         last_ff, nxt_last;
	logic               rd_ff, nxt_rd;
	fai_pkg::fai_req_t  cur_ff, nxt_cur;
	logic               ready_ff, nxt_ready;
	logic               rv_ff, nxt_rv;
	logic [15:0]        rdat_ff, nxt_rdat;
	logic               prot_ff, nxt_prot;
	logic               idm_ff, nxt_idm;
	logic               err_ff, nxt_err;
	logic [ADDR_W-1:0]  addr_ff, nxt_addr;
	logic [15:0]        dqo_ff, nxt_dqo;
	logic               dqoe_ff, nxt_dqoe;
	fai_pkg::fai_ctl_t  ctl_ff, nxt_ctl;

	// Next-state logic for the bus sequencer
	always_comb begin
		nxt_st    = st_ff;
		nxt_cnt   = cnt_ff;
		nxt_step  = step_ff;
		nxt_last  = last_ff;
		nxt_rd    = rd_ff;
		nxt_cur   = cur_ff;
		nxt_ready = 1'b0;
		nxt_rv    = 1'b0;
		nxt_rdat  = rdat_ff;
		nxt_prot  = prot_ff;
		nxt_idm   = idm_ff;
		nxt_err   = 1'b0;
		nxt_addr  = addr_ff;
		nxt_dqo   = dqo_ff;
		nxt_dqoe  = dqoe_ff;
		nxt_ctl   = ctl_ff;
		case (st_ff)
			ST_IDLE: begin
				nxt_ready = 1'b1;
				if (req_valid && ready_ff) begin
					nxt_ready = 1'b0;
					nxt_cur   = req;
					nxt_step  = 2'h0;
					nxt_cnt   = `FAI_SETUP_CYC;
					nxt_st    = ST_SETUP;
					case (req.op)
						fai_pkg::FAI_OP_ENTER: begin
							// entry only from a read mode
							if (dev_busy || idm_ff) begin
								nxt_err = 1'b1;
								nxt_st  = ST_DONE;
							end
							nxt_last = 2'h2;
							nxt_rd   = 1'b0;
						end
						fai_pkg::FAI_OP_READ: begin
							// reads only while mode is held
							if (!idm_ff) begin
								nxt_err = 1'b1;
								nxt_st  = ST_DONE;
							end
							nxt_last = 2'h0;
							nxt_rd   = 1'b1;
						end
						fai_pkg::FAI_OP_EXIT: begin
							nxt_last = 2'h0;
							nxt_rd   = 1'b0;
						end
						fai_pkg::FAI_OP_HV_ON: begin
							if (!power_good || idm_ff) begin
								nxt_err = 1'b1;
							end else begin
								nxt_ctl.a9_hv = 1'b1;
								nxt_idm       = 1'b1;
							end
							nxt_st = ST_DONE;
						end
						default: begin
							nxt_ctl.a9_hv = 1'b0;
							nxt_idm       = 1'b0;
							nxt_st        = ST_DONE;
						end
					endcase
				end
				// drop high voltage when power goes
				if (!power_good && ctl_ff.a9_hv) begin
					nxt_ctl.a9_hv = 1'b0;
					nxt_idm       = 1'b0;
				end
			end
			ST_SETUP: begin
				// Address, data and strobes for this bus cycle
				case (cur_ff.op)
					fai_pkg::FAI_OP_ENTER: begin
						case (step_ff)
							2'h0: begin
								nxt_addr = word_addr(`FAI_UNLOCK1_ADDR);
								nxt_dqo  = `FAI_UNLOCK1_DATA;
							end
							2'h1: begin
								nxt_addr = word_addr(`FAI_UNLOCK2_ADDR);
								nxt_dqo  = `FAI_UNLOCK2_DATA;
							end
							default: begin
								nxt_addr = word_addr(`FAI_CMD_ADDR);
								nxt_dqo  = `FAI_ID_CMD_DATA;
							end
						endcase
					end
					fai_pkg::FAI_OP_EXIT: begin
						// exit value at a fixed offset
						nxt_addr = word_addr(`FAI_EXIT_ADDR);
						nxt_dqo  = `FAI_EXIT_DATA;
					end
					default: begin
						// item on A3..A0 with A6 low
						nxt_addr = item_addr(cur_ff.sector, cur_ff.item);
					end
				endcase
				nxt_dqoe     = !rd_ff;
				nxt_ctl.ce_n = 1'b0;
				if (cnt_ff == 4'h0) begin
					// strobe on: output enable low for reads, write enable low for writes
					nxt_ctl.oe_n = !rd_ff;
					nxt_ctl.we_n = rd_ff;
					nxt_cnt      = `FAI_STROBE_CYC;
					nxt_st       = ST_STROBE;
				end else begin
					nxt_cnt = cnt_ff - 4'h1;
				end
			end
			ST_STROBE: begin
				if (cnt_ff == 4'h0) begin
					if (rd_ff) begin
						// code captured from the data bus
						nxt_rdat = dq_in;
						nxt_prot = dq_in[`FAI_PROT_BIT];
					end
					nxt_ctl.oe_n = 1'b1;
					nxt_ctl.we_n = 1'b1;
					nxt_cnt      = `FAI_HOLD_CYC;
					nxt_st       = ST_HOLD;
				end else begin
					nxt_cnt = cnt_ff - 4'h1;
				end
			end
			ST_HOLD: begin
				nxt_ctl.ce_n = 1'b1;
				nxt_dqoe     = 1'b0;
				if (cnt_ff == 4'h0) begin
					if (step_ff == last_ff) begin
						nxt_st = ST_DONE;
						nxt_rv = rd_ff;
						if (cur_ff.op == fai_pkg::FAI_OP_ENTER) begin
							nxt_idm = 1'b1;
						end
						if (cur_ff.op == fai_pkg::FAI_OP_EXIT) begin
							nxt_idm       = 1'b0;
							nxt_ctl.a9_hv = 1'b0;
						end
					end else begin
						nxt_step = step_ff + 2'h1;
						nxt_cnt  = `FAI_SETUP_CYC;
						nxt_st   = ST_SETUP;
					end
				end else begin
					nxt_cnt = cnt_ff - 4'h1;
				end
			end
			ST_DONE: begin
				nxt_st = ST_IDLE;
			end
			default: begin
				nxt_st = ST_IDLE;
			end
		endcase
	end

	// Register every piece of state
	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_ff    <= ST_IDLE;
			cnt_ff   <= 4'h0;
			step_ff  <= 2'h0;
			last_ff  <= 2'h0;
			rd_ff    <= 1'b0;
			cur_ff   <= '0;
			ready_ff <= 1'b0;
			rv_ff    <= 1'b0;
			rdat_ff  <= 16'h0000;
			prot_ff  <= 1'b0;
			idm_ff   <= 1'b0;
			err_ff   <= 1'b0;
			addr_ff  <= '0;
			dqo_ff   <= 16'h0000;
			dqoe_ff  <= 1'b0;
			ctl_ff   <= 4'he;
		end else begin
			st_ff    <= nxt_st;
			cnt_ff   <= nxt_cnt;
			step_ff  <= nxt_step;
			last_ff  <= nxt_last;
			rd_ff    <= nxt_rd;
			cur_ff   <= nxt_cur;
			ready_ff <= nxt_ready;
			rv_ff    <= nxt_rv;
			rdat_ff  <= nxt_rdat;
			prot_ff  <= nxt_prot;
			idm_ff   <= nxt_idm;
			err_ff   <= nxt_err;
			addr_ff  <= nxt_addr;
			dqo_ff   <= nxt_dqo;
			dqoe_ff  <= nxt_dqoe;
			ctl_ff   <= nxt_ctl;
		end
	end

	// Outputs straight from flops
	assign req_ready     = ready_ff;
	assign rsp_valid     = rv_ff;
	assign rsp_data      = rdat_ff;
	assign rsp_protected = prot_ff;
	assign in_id_mode    = idm_ff;
	assign req_error     = err_ff;
	assign addr          = addr_ff;
	assign dq_out        = dqo_ff;
	assign dq_oe         = dqoe_ff;
	assign ctl           = ctl_ff;

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	sequence s_read_strobe;
		!ctl_ff.ce_n && !ctl_ff.oe_n && ctl_ff.we_n;
	endsequence

	// read strobes never overlap a write
	AST_READ_STROBES: assert property (@(posedge core_clk) disable iff (rst)
		!ctl_ff.oe_n |-> (ctl_ff.we_n && !ctl_ff.ce_n && !dqoe_ff))
		else $error("read strobe with write enable or data drive");

	AST_NO_ENTRY_BUSY: assert property (@(posedge core_clk) disable iff (rst)
		(st_ff == ST_IDLE && ready_ff && req_valid && req.op == fai_pkg::FAI_OP_ENTER && dev_busy)
		|=> (st_ff == ST_DONE && err_ff))
		else $error("entry accepted while device busy");

	// first entry write goes to the first unlock offset
	AST_UNLOCK1: assert property (@(posedge core_clk) disable iff (rst)
		(!ctl_ff.we_n && cur_ff.op == fai_pkg::FAI_OP_ENTER && step_ff == 2'h0)
		|-> (addr_ff == word_addr(`FAI_UNLOCK1_ADDR) && dqo_ff == `FAI_UNLOCK1_DATA))
		else $error("first unlock write wrong");

	// exit clears the mode at completion
	AST_EXIT_CLEARS: assert property (@(posedge core_clk) disable iff (rst)
		(st_ff == ST_HOLD && cnt_ff == 4'h0 && cur_ff.op == fai_pkg::FAI_OP_EXIT) |=> !idm_ff)
		else $error("mode still set after exit");

	// high voltage stays on while reads run in that mode
	AST_HV_HELD: assert property (@(posedge core_clk) disable iff (rst)
		(s_read_strobe ##0 ctl_ff.a9_hv) |=> ctl_ff.a9_hv)
		else $error("high voltage dropped during read");

	// high voltage only with power good
	AST_HV_POWER: assert property (@(posedge core_clk) disable iff (rst)
		$rose(ctl_ff.a9_hv) |-> $past(power_good))
		else $error("high voltage applied without power");

	// read address carries item and A6 low
	AST_ITEM_ADDR: assert property (@(posedge core_clk) disable iff (rst)
		s_read_strobe |-> (addr_ff[3:0] == cur_ff.item && !addr_ff[6]))
		else $error("item select address wrong");

	AST_MODE_HELD: assert property (@(posedge core_clk) disable iff (rst)
		(idm_ff && st_ff == ST_SETUP && rd_ff) |=> idm_ff)
		else $error("mode lost during read");

	// word and protection flag taken from the bus at strobe end
	AST_PROT_FLAG: assert property (@(posedge core_clk) disable iff (rst)
		(st_ff == ST_STROBE && cnt_ff == 4'h0 && rd_ff)
		|=> (prot_ff == $past(dq_in[`FAI_PROT_BIT]) && rdat_ff == $past(dq_in)))
		else $error("protection flag mismatch");

endmodule // fai_host

// ===== tb/fai_flash_model.sv
`timescale 1ns/100ps
//////////////////////////////////////////////////
// Behavioural flash device, identification mode
module fai_flash_model #(
	parameter int          ADDR_W = 26,
	// Identity values are arbitrary
	parameter logic [15:0] MANUF  = 16'h00c3,
	parameter logic [15:0] DEV1   = 16'h5a11,
	parameter logic [15:0] DEV2   = 16'h5a22,
	parameter logic [15:0] DEV3   = 16'h5a33,
	parameter logic [15:0] SECURE = 16'h0044
) (
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [15:0]       dq_out,
	input  wire logic              dq_oe,
	input  wire fai_pkg::fai_ctl_t ctl,
	output logic [15:0]            dq_in,
	output logic                   id_mode
);
	logic [1:0]  step;
	logic [15:0] val;
	logic [15:0] last;
	logic        rd;
	logic [10:0] off;

	initial begin
		step = 2'h0;
		id_mode = 1'b0;
		last = 16'h0000;
	end
	assign off = addr[10:0];
	always @(posedge ctl.we_n) begin
		if (!ctl.ce_n && dq_oe) begin
			if (dq_out == 16'h00f0) begin
				id_mode = 1'b0;
				step = 2'h0;
			end else if (step == 2'h0 && off == 11'h555 && dq_out == 16'h00aa)
				step = 2'h1;
			else if (step == 2'h1 && off == 11'h2aa && dq_out == 16'h0055)
				step = 2'h2;
			else begin
				id_mode = id_mode || (step == 2'h2 && off == 11'h555 && dq_out == 16'h0090);
				step = 2'h0;
			end
		end
	end
	always_comb begin
		case (addr[3:0])
			4'h0: val = MANUF;
			4'h1: val = DEV1;
			4'he: val = DEV2;
			4'hf: val = DEV3;
			4'h2: val = {15'h0000, addr[ADDR_W-10]};
			4'h3: val = SECURE;
			default: val = 16'h6d6d;
		endcase
		if (addr[6] || !(id_mode || ctl.a9_hv))
			val = 16'h7777;  // Array stand-in
	end
	// item value on the bus only in a read cycle
	assign rd = !ctl.ce_n && !ctl.oe_n && ctl.we_n;
	always @(val or rd)
		if (rd)
			last = val;
	// Released bus shows inverse of last word
	assign dq_in = rd ? val : ~last;
endmodule // fai_flash_model

// ===== tb/fai_host_bench.sv
`timescale 1ns/100ps
//////////////////////////////////////////////////
// Bench of the identification host
module fai_host_bench;
	localparam logic [3:0]  ITEMS [4] = '{4'h0, 4'h1, 4'he, 4'hf};
	localparam logic [15:0] CODES [4] = '{16'h00c3, 16'h5a11, 16'h5a22, 16'h5a33};
	logic               core_clk, rst, req_valid, dev_busy, power_good;
	fai_pkg::fai_req_t  req;
	logic [15:0]        dq_in, rsp_data, dq_out;
	logic               req_ready, rsp_valid, rsp_protected, in_id_mode;
	logic               req_error, dq_oe, dev_mode;
	logic [25:0]        addr;
	fai_pkg::fai_ctl_t  ctl;
	int                 bad_count, checks_done, cyc;

	fai_host fai_host_inst (.core_clk(core_clk), .rst(rst), .req(req), .req_valid(req_valid),
		.dev_busy(dev_busy), .power_good(power_good), .dq_in(dq_in), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_protected(rsp_protected),
		.in_id_mode(in_id_mode), .req_error(req_error), .addr(addr), .dq_out(dq_out),
		.dq_oe(dq_oe), .ctl(ctl));
	fai_flash_model fai_flash_model_inst (.addr(addr), .dq_out(dq_out), .dq_oe(dq_oe),
		.ctl(ctl), .dq_in(dq_in), .id_mode(dev_mode));

	// Clock and cycle ceiling
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			end_of_test();
		end
	end
	// never read and write strobes together
	always @(posedge core_clk)
		if (!rst && !ctl.oe_n && !ctl.we_n) begin
			bad_count++;
			$display("wrong value at %0t: oe_n %h we_n %h", $time, ctl.oe_n, ctl.we_n);
		end
	//////////////////////////////////////////////////
	// Shared tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic send(input fai_pkg::fai_op_t op, input logic [3:0] it, input logic [9:0] sc);
		int n;
		n = 0;
		req = {op, it, sc};
		req_valid = 1'b1;
		// Ready settled between edges is what the next edge takes
		while (req_ready !== 1'b1 && n < 100) begin
			n++;
			@(posedge core_clk);
			#1;
		end
		@(posedge core_clk);
		#1 req_valid = 1'b0;
	endtask
	task automatic rd_item(input logic [3:0] it, input logic [9:0] sc, input logic [15:0] exp);
		int n;
		n = 0;
		send(fai_pkg::FAI_OP_READ, it, sc);
		while (rsp_valid !== 1'b1 && n < 40) begin
			n++;
			@(posedge core_clk);
			#1;
		end
		chk(rsp_valid, 16'h0001);
		chk(rsp_data, exp);
	endtask
	task automatic refused(input fai_pkg::fai_op_t op);
		logic e, b;
		e = 1'b0;
		b = 1'b0;
		send(op, 4'h0, 10'h000);
		repeat (3) begin
			e = e | (req_error === 1'b1);
			b = b | (ctl.ce_n !== 1'b1);
			@(posedge core_clk);
			#1;
		end
		chk(e, 16'h0001);
		chk(b, 16'h0000);
	endtask
	task automatic wait_mode(input logic lvl);
		int n;
		n = 0;
		while (in_id_mode !== lvl && n < 100) begin
			n++;
			@(posedge core_clk);
			#1;
		end
		chk(in_id_mode, lvl);
		chk(dev_mode, lvl);
	endtask
	//////////////////////////////////////////////////
	// Scenarios
	task automatic t_refuse();
		refused(fai_pkg::FAI_OP_READ);
		dev_busy = 1'b1;
		refused(fai_pkg::FAI_OP_ENTER);
		dev_busy = 1'b0;
		power_good = 1'b0;
		refused(fai_pkg::FAI_OP_HV_ON);
		power_good = 1'b1;
	endtask
	task automatic t_cmd();
		send(fai_pkg::FAI_OP_ENTER, 4'h0, 10'h000);
		wait_mode(1'b1);
		for (int i = 0; i < 4; i++)
			rd_item(ITEMS[i], 10'h155, CODES[i]);
		rd_item(4'h2, 10'h003, 16'h0001);
		chk(rsp_protected, 16'h0001);
		rd_item(4'h2, 10'h004, 16'h0000);
		chk(rsp_protected, 16'h0000);
		rd_item(4'h3, 10'h000, 16'h0044);
		refused(fai_pkg::FAI_OP_ENTER);
		send(fai_pkg::FAI_OP_EXIT, 4'h0, 10'h000);
		wait_mode(1'b0);
	endtask
	task automatic t_hv();
		send(fai_pkg::FAI_OP_HV_ON, 4'h0, 10'h000);
		repeat (2) @(posedge core_clk);
		#1 chk(ctl.a9_hv, 16'h0001);
		rd_item(4'h1, 10'h000, CODES[1]);
		chk(ctl.a9_hv, 16'h0001);
		send(fai_pkg::FAI_OP_HV_OFF, 4'h0, 10'h000);
		repeat (2) @(posedge core_clk);
		#1 chk(ctl.a9_hv, 16'h0000);
		send(fai_pkg::FAI_OP_HV_ON, 4'h0, 10'h000);
		power_good = 1'b0;
		repeat (3) @(posedge core_clk);
		#1 chk({ctl.a9_hv, in_id_mode}, 16'h0000);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Main sequence
	initial begin
		rst = 1'b1;
		req_valid = 1'b0;
		req = '0;
		dev_busy = 1'b0;
		power_good = 1'b1;
		repeat (2) @(posedge core_clk);
		#1 rst = 1'b0;
		chk({ctl, dq_oe, in_id_mode}, 16'h0038);
		t_refuse();
		t_cmd();
		t_hv();
		end_of_test();
	end
endmodule // fai_host_bench
